/* addr_map_chk.sv */
// Concurrent checks on the ports of the system address map decoder.
// Assumes the decoder constants header and one clock domain with rst.
`include "addr_map_defs.vh"

module addr_map_chk (
  input wire          clk,
  input wire          rst,
  input wire          req_valid,
  input wire          req_ready,
  input wire [31:0]   req_addr,
  input wire          req_fetch,
  input wire          resp_valid_r,
  input wire          resp_err_r,
  input wire          tgt_valid_r,
  input wire [8:0]    tgt_sel_r,
  input wire [31:0]   tgt_addr_r,
  input wire          tgt_write_r,
  input wire          tgt_ready,
  input wire          path_icode,
  input wire          path_dcode,
  input wire          path_sys,
  input wire          path_ppb,
  input wire [23:0]   ext_addr_r,
  input wire          bb_lock
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [3:0] paths = {path_ppb, path_sys, path_dcode, path_icode};
  wire       take  = req_valid && req_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Select ranges are judged on the first beat only: a split access keeps its first select.
  a_one_path: assert property ($onehot(paths) == tgt_valid_r) else $error("bus path not one-hot");
  a_code_only: assert property ((path_icode || path_dcode) |-> tgt_addr_r <= `CODE_HI)
    else $error("code path outside code region");
  a_sys_span: assert property (path_sys |-> tgt_addr_r >= `SRAM_RGN_LO && tgt_addr_r[31:20] != 12'hE00)
    else $error("system path outside its spans");
  a_ppb_window: assert property (path_ppb |-> tgt_addr_r[31:20] == 12'hE00 && tgt_sel_r == 9'h000)
    else $error("private bus outside its window");
  a_clk_block: assert property ($rose(tgt_valid_r) && tgt_sel_r[`T_CLK] |->
    tgt_addr_r >= `CLK_LO && tgt_addr_r <= `CLK_HI) else $error("clock block select out of range");
  a_external_memory_interface_regs: assert property ($rose(tgt_valid_r) && tgt_sel_r[`T_EMIFR] |->
    tgt_addr_r[31:8] == 24'h400054) else $error("memory interface register select out of range");
  a_code_sram: assert property ($rose(tgt_valid_r) && tgt_sel_r[`T_SRAMC] |->
    tgt_addr_r[31:15] == 17'h03FFF) else $error("code SRAM select out of range");
  a_region_sram: assert property ($rose(tgt_valid_r) && tgt_sel_r[`T_SRAMS] |->
    tgt_addr_r[31:15] == 17'h04000) else $error("SRAM block select out of range");
  a_ext_bits: assert property ($rose(tgt_valid_r) && tgt_sel_r[`T_XMEM] |->
    ext_addr_r[23:2] == tgt_addr_r[23:2] && tgt_addr_r[31:24] == 8'h60) else $error("external address wrong");
  a_ext_zero: assert property (tgt_valid_r && !tgt_sel_r[`T_XMEM] |-> ext_addr_r == 24'h000000)
    else $error("external address shown for another target");
  a_lock_rmw: assert property ($rose(bb_lock) |-> tgt_valid_r && !tgt_write_r && tgt_sel_r[`T_SRAMS])
    else $error("bit lock without SRAM read beat");
  a_unmapped_err: assert property (take && req_addr >= 32'h00100000 && req_addr < `SRAMC_LO |=>
    resp_valid_r && resp_err_r && !tgt_valid_r) else $error("unmapped access not refused");
  a_fetch_ppb: assert property (take && req_fetch && req_addr >= `PPB_LO |=> resp_valid_r && resp_err_r)
    else $error("fetch from internal peripherals not refused");
  a_no_hang: assert property (tgt_valid_r && tgt_ready |=> resp_valid_r || tgt_valid_r)
    else $error("access lost after beat");
endmodule

bind system_address_map_decoder addr_map_chk i_addr_map_chk (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
  .req_fetch(req_fetch), .resp_valid_r(resp_valid_r), .resp_err_r(resp_err_r), .tgt_valid_r(tgt_valid_r),
  .tgt_sel_r(tgt_sel_r), .tgt_addr_r(tgt_addr_r), .tgt_write_r(tgt_write_r), .tgt_ready(tgt_ready),
  .path_icode(path_icode), .path_dcode(path_dcode), .path_sys(path_sys), .path_ppb(path_ppb),
  .ext_addr_r(ext_addr_r), .bb_lock(bb_lock));

/* addr_map_defs.vh */
// Constants for the system address map decoder: region bounds, target
// indices, bus path codes and access sizes.
// Assumes it is included by bare name from the design files.
`ifndef ADDR_MAP_DEFS_VH
`define ADDR_MAP_DEFS_VH

// ----------------------------------------------------------------------
// Top-level regions
// ----------------------------------------------------------------------
`define CODE_LO      32'h00000000
`define CODE_HI      32'h1FFFFFFF
`define SRAM_RGN_LO  32'h20000000
`define SRAM_RGN_HI  32'h3FFFFFFF
`define PERI_LO      32'h40000000
`define PERI_HI      32'h5FFFFFFF
`define XRAM_LO      32'h60000000
`define XRAM_HI      32'h9FFFFFFF
`define XPER_LO      32'hA0000000
`define XPER_HI      32'hDFFFFFFF
`define PPB_LO       32'hE0000000
`define PPB_HI       32'hE00FFFFF
`define SYSI_LO      32'hE0100000
`define SYSI_HI      32'hFFFFFFFF

// ----------------------------------------------------------------------
// Mapped blocks
// ----------------------------------------------------------------------
`define FLASH_LO     32'h00000000
`define FLASH_HI     32'h0003FFFF
`define SRAMC_LO     32'h1FFF8000
`define SRAMC_HI     32'h1FFFFFFF
`define SRAMS_LO     32'h20000000
`define SRAMS_HI     32'h20007FFF
`define CLK_LO       32'h40004000
`define CLK_HI       32'h400042FF
`define EMIFR_LO     32'h40005400
`define EMIFR_HI     32'h400054FF
`define XMEM_LO      32'h60000000
`define XMEM_HI      32'h60FFFFFF
`define XMEM_AW      24

// ----------------------------------------------------------------------
// Bit-band windows
// ----------------------------------------------------------------------
`define BB_TGT_LO    32'h20000000
`define BB_TGT_HI    32'h200FFFFF
`define BB_ALIAS_LO  32'h22000000
`define BB_ALIAS_HI  32'h23FFFFFF

// ----------------------------------------------------------------------
// Target select indices, bus paths, sizes
// ----------------------------------------------------------------------
`define T_FLASH      0
`define T_SRAMC      1
`define T_SRAMS      2
`define T_CLK        3
`define T_EMIFR      4
`define T_PERI       5
`define T_XMEM       6
`define T_XPER       7
`define T_SYSI       8
`define NT           9
`define P_ICODE      2'h0
`define P_DCODE      2'h1
`define P_SYS        2'h2
`define P_PPB        2'h3
`define SZ_BYTE      2'h0
`define SZ_HALF      2'h1
`define SZ_WORD      2'h2

`endif

/* addr_region_decoder.v */
// Combinational region decoder: one-hot target select, bus path and hit.
// Assumes a 32-bit byte address and a flag marking instruction fetches.
`include "addr_map_defs.vh"

module addr_region_decoder (
  input  wire [31:0]    addr,
  input  wire           fetch,
  output reg  [`NT-1:0] sel,
  output reg  [1:0]     path,
  output wire           hit
);

  function in_rng;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  // Fetches from peripheral and internal regions find no target, so they
  // end in a bus error instead of executing device registers.
  always @* begin
    sel  = {`NT{1'b0}};
    path = `P_SYS;
    if (in_rng(addr, `CODE_LO, `CODE_HI)) begin
      path = fetch ? `P_ICODE : `P_DCODE; // RULE_01
      sel[`T_FLASH] = in_rng(addr, `FLASH_LO, `FLASH_HI);
      sel[`T_SRAMC] = in_rng(addr, `SRAMC_LO, `SRAMC_HI); // RULE_11
    end else if (in_rng(addr, `SRAM_RGN_LO, `SRAM_RGN_HI)) begin
      // Fetches are taken here over the system bus. RULE_03
      sel[`T_SRAMS] = in_rng(addr, `SRAMS_LO, `SRAMS_HI) || // RULE_12
                      in_rng(addr, `BB_ALIAS_LO, `BB_ALIAS_HI);
    end else if (in_rng(addr, `PERI_LO, `PERI_HI) && !fetch) begin
      sel[`T_CLK]   = in_rng(addr, `CLK_LO, `CLK_HI); // RULE_13
      sel[`T_EMIFR] = in_rng(addr, `EMIFR_LO, `EMIFR_HI); // RULE_14
      sel[`T_PERI]  = !sel[`T_CLK] && !sel[`T_EMIFR];
    end else if (in_rng(addr, `XRAM_LO, `XRAM_HI)) begin
      sel[`T_XMEM] = in_rng(addr, `XMEM_LO, `XMEM_HI);
    end else if (in_rng(addr, `XPER_LO, `XPER_HI)) begin
      sel[`T_XPER] = !fetch; // RULE_02
    end else if (in_rng(addr, `PPB_LO, `PPB_HI)) begin
      path = `P_PPB; // RULE_04 RULE_05 RULE_15
    end else begin
      sel[`T_SYSI] = !fetch; // RULE_02 RULE_05
    end
  end

  // The private peripheral window has no select line of its own: its path
  // code alone steers the access, and fetches there are refused.
  assign hit = (|sel) || (path == `P_PPB && !fetch);

endmodule

/* bitband_xlate.v */
// Bit-band alias translation: alias address to target word and bit, and the
// set/clear merge of one bit into a word read back from SRAM.
// Assumes the caller has already recognised the alias window.
`include "addr_map_defs.vh"

module bitband_xlate (
  input  wire [31:0] addr,
  input  wire [31:0] word,
  input  wire        wbit,
  output wire        is_alias,
  output wire [31:0] tgt_addr,
  output wire        in_sram,
  output wire [31:0] merged,
  output wire [31:0] bit_rd
);

  wire [4:0]  bit_idx;
  wire [31:0] bit_mask;

  assign is_alias = (addr >= `BB_ALIAS_LO) && (addr <= `BB_ALIAS_HI); // RULE_07
  // Alias = base + 32 * byte offset + 4 * bit, so the word is addr[24:7]
  // and the bit within it is addr[6:2].
  assign tgt_addr = `BB_TGT_LO + {12'h000, addr[24:7], 2'b00}; // RULE_06 RULE_17
  assign bit_idx  = addr[6:2]; // RULE_17
  // Only the low 32 KB of the 1 MB target window is backed by SRAM.
  assign in_sram  = (tgt_addr <= `SRAMS_HI);
  assign bit_mask = 32'h00000001 << bit_idx;
  assign merged   = wbit ? (word | bit_mask) : (word & ~bit_mask); // RULE_08
  assign bit_rd   = {31'h00000000, word[bit_idx]}; // RULE_09

endmodule

/* mem_target.sv */
// Target-side model: one word store answering every beat after a set stall.
// Assumes callers keep addresses distinct in bits 9:2.
module mem_target (
  input  wire        clk,
  input  wire        rst,
  input  wire        tgt_valid_r,
  input  wire [31:0] tgt_addr_r,
  input  wire        tgt_write_r,
  input  wire [3:0]  tgt_be_r,
  input  wire [31:0] tgt_wdata_r,
  input  wire [2:0]  stall,
  input  wire        err_in,
  output wire        tgt_ready,
  output wire [31:0] tgt_rdata,
  output wire        tgt_err
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [31:0] mem [0:255];
  reg [2:0]  wait_r;
  wire [7:0] idx = tgt_addr_r[9:2];
  integer    b;
  assign tgt_ready = tgt_valid_r && wait_r == stall;
  // Outside a taken beat the data lines show the inverse, never a stale match.
  assign tgt_rdata = tgt_ready ? mem[idx] : ~mem[idx];
  assign tgt_err   = tgt_ready && err_in;
  initial for (b = 0; b < 256; b = b + 1) mem[b] = 32'h00000000;
  always @(posedge clk) begin
    wait_r <= (rst || !tgt_valid_r || tgt_ready) ? 3'h0 : wait_r + 3'h1;
    if (tgt_ready && tgt_write_r && !err_in)
      for (b = 0; b < 4; b = b + 1)
        if (tgt_be_r[b]) mem[idx][8*b +: 8] <= tgt_wdata_r[8*b +: 8];
  end
endmodule

/* system_address_map_decoder.v */
// System address map decoder and bus steering for a 32-bit core subsystem.
// Assumes one request at a time from the core side, and targets that answer
// each beat with tgt_ready (and tgt_err) while tgt_valid is high.
//
// Function
// [RULE_01] Only code-region addresses go on the instruction-code and data-code paths.
// [RULE_02] Data and debug accesses use the system bus for SRAM..external and high ranges.
// [RULE_03] Instruction fetches are allowed over the system bus in the SRAM region; the code ends fetches to the bit-band alias window in a bus error instead.
// [RULE_04] System control and debug registers go over the private peripheral bus.
// [RULE_05] The top half-gigabyte from 0xE0000000 holds internal peripherals.
// [RULE_06] A 1 MB bit-band target window starts at the SRAM region base.
// [RULE_07] A 32 MB alias window at 0x22000000 maps one word to each target bit.
// [RULE_08] Alias writes atomically set or clear one SRAM bit from data bit 0.
// [RULE_09] Alias reads return 0 or 1, the current state of the SRAM bit.
// [RULE_10] Unaligned word and half-word accesses are accepted, with extra cycles.
// [RULE_11] A 32 KB SRAM block sits at the top of the code region.
// [RULE_12] A second 32 KB SRAM block starts at the SRAM region base.
// [RULE_13] The clock, PLL and oscillator block is selected within its range.
// [RULE_14] The external memory interface registers are selected within 256 bytes.
// [RULE_15] Private peripheral registers occupy the 1 MB window at 0xE0000000.
// [RULE_16] External memory accesses drive at most 24 address bits.
// [RULE_17] Alias address is base plus 32 times byte offset plus 4 times bit.
// [RULE_18] Accesses that select nothing end with a bus error, never a hang.
`include "addr_map_defs.vh"

module system_address_map_decoder (
  input  wire           clk,
  input  wire           rst,
  input  wire           req_valid,
  output wire           req_ready,
  input  wire [31:0]    req_addr,
  input  wire           req_write,
  input  wire [1:0]     req_size,
  input  wire [31:0]    req_wdata,
  input  wire           req_fetch,
  input  wire           req_debug,
  output reg            resp_valid_r,
  output reg            resp_err_r,
  output reg  [31:0]    resp_rdata_r,
  output reg            tgt_valid_r,
  output reg  [`NT-1:0] tgt_sel_r,
  output reg  [31:0]    tgt_addr_r,
  output reg            tgt_write_r,
  output reg  [3:0]     tgt_be_r,
  output reg  [31:0]    tgt_wdata_r,
  output reg            tgt_debug_r,
  input  wire           tgt_ready,
  input  wire [31:0]    tgt_rdata,
  input  wire           tgt_err,
  output wire           path_icode,
  output wire           path_dcode,
  output wire           path_sys,
  output wire           path_ppb,
  output reg  [23:0]    ext_addr_r,
  output wire           bb_lock
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_BEAT0 = 3'h1;
  localparam [2:0] S_BEAT1 = 3'h2;
  localparam [2:0] S_BBRD  = 3'h3;
  localparam [2:0] S_BBWR  = 3'h4;

  reg [2:0]  state_r;
  reg [1:0]  path_r;
  reg [1:0]  off_r;
  reg [1:0]  size_r;
  reg        write_r;
  reg        wbit_r;
  reg [3:0]  be_hi_r;
  reg [31:0] wdata_hi_r;
  reg [31:0] rd0_r;
  // Bit number of an alias access, held for its read-modify-write.
  reg [4:0]  bidx_r;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Size code 3 is reserved and taken as a word, so no beat is ever issued
  // with all byte lanes off.
  function [3:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        `SZ_BYTE: size_mask = 4'h1;
        `SZ_HALF: size_mask = 4'h3;
        default:  size_mask = 4'hF;
      endcase
    end
  endfunction

  // Byte lanes over two consecutive words; lanes [7:4] belong to the
  // second beat of an access that crosses a word boundary.
  function [7:0] lanes;
    input [1:0] off;
    input [1:0] sz;
    begin
      lanes = {4'h0, size_mask(sz)} << off;
    end
  endfunction

  // Read data leaves right-aligned and zero-extended, so a narrow read never
  // carries bytes from lanes outside the access.
  function [31:0] extract;
    input [63:0] w;
    input [1:0]  off;
    input [1:0]  sz;
    reg   [63:0] s;
    begin
      s = w >> {off, 3'b000};
      case (sz)
        `SZ_BYTE: extract = {24'h000000, s[7:0]};
        `SZ_HALF: extract = {16'h0000, s[15:0]};
        default:  extract = s[31:0];
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Decode and bit-band translation
  // --------------------------------------------------------------------
  wire [`NT-1:0] dec_sel;
  wire [1:0]     dec_path;
  wire           dec_hit;
  wire           bb_alias;
  wire [31:0]    bb_tgt;
  wire           bb_in_sram;
  wire [31:0]    bb_merged;
  wire [31:0]    bb_bit;

  addr_region_decoder u_dec (
    .addr  (req_addr),
    .fetch (req_fetch),
    .sel   (dec_sel),
    .path  (dec_path),
    .hit   (dec_hit)
  );

  // The core may move req_addr once a request is taken, so during the
  // read-modify-write the translator sees the bit number latched at the take.
  // In idle the live address is used to find the target word and to refuse
  // accesses beyond the backed part of the window.
  wire [31:0] bb_addr = req_ready ? req_addr : {25'h0000000, bidx_r, 2'b00};

  bitband_xlate u_bb (
    .addr     (bb_addr),
    .word     (tgt_rdata),
    .wbit     (wbit_r),
    .is_alias (bb_alias),
    .tgt_addr (bb_tgt),
    .in_sram  (bb_in_sram),
    .merged   (bb_merged),
    .bit_rd   (bb_bit)
  );

  wire [7:0]  req_lanes = lanes(req_addr[1:0], req_size);
  wire [63:0] req_wide  = {32'h00000000, req_wdata} << {req_addr[1:0], 3'b000};
  wire        bad       = !dec_hit || (bb_alias && (!bb_in_sram || req_fetch));
  wire        beat_ok   = tgt_valid_r && tgt_ready;

  assign req_ready  = (state_r == S_IDLE);
  assign path_icode = tgt_valid_r && (path_r == `P_ICODE); // RULE_01
  assign path_dcode = tgt_valid_r && (path_r == `P_DCODE); // RULE_01
  assign path_sys   = tgt_valid_r && (path_r == `P_SYS); // RULE_02
  assign path_ppb   = tgt_valid_r && (path_r == `P_PPB); // RULE_04
  // Held across both halves so no other master can slip in between.
  assign bb_lock    = (state_r == S_BBRD) || (state_r == S_BBWR); // RULE_08

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  // A split access keeps the select of its first word, so an access must not
  // straddle two regions. bb_lock spans both alias beats; the system must not
  // grant the target to another master while it is high.
  always @(posedge clk) begin
    if (rst) begin
      state_r      <= S_IDLE;
      resp_valid_r <= 1'b0;
      resp_err_r   <= 1'b0;
      resp_rdata_r <= 32'h00000000;
      tgt_valid_r  <= 1'b0;
      tgt_sel_r    <= {`NT{1'b0}};
      tgt_addr_r   <= 32'h00000000;
      tgt_write_r  <= 1'b0;
      tgt_be_r     <= 4'h0;
      tgt_wdata_r  <= 32'h00000000;
      tgt_debug_r  <= 1'b0;
      ext_addr_r   <= 24'h000000;
      path_r       <= `P_SYS;
      off_r        <= 2'h0;
      size_r       <= `SZ_WORD;
      write_r      <= 1'b0;
      wbit_r       <= 1'b0;
      be_hi_r      <= 4'h0;
      wdata_hi_r   <= 32'h00000000;
      rd0_r        <= 32'h00000000;
      bidx_r       <= 5'h00;
    end else begin
      resp_valid_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (req_valid) begin
            path_r      <= dec_path;
            off_r       <= req_addr[1:0];
            size_r      <= req_size;
            write_r     <= req_write;
            wbit_r      <= req_wdata[0]; // RULE_08
            bidx_r      <= req_addr[6:2]; // RULE_17
            tgt_sel_r   <= dec_sel;
            tgt_debug_r <= req_debug;
            if (bad) begin
              resp_valid_r <= 1'b1; // RULE_18
              resp_err_r   <= 1'b1;
              resp_rdata_r <= 32'h00000000;
              ext_addr_r   <= 24'h000000;
            end else if (bb_alias) begin
              tgt_valid_r <= 1'b1;
              tgt_addr_r  <= bb_tgt; // RULE_17
              ext_addr_r  <= 24'h000000; // RULE_16
              tgt_write_r <= 1'b0;
              tgt_be_r    <= 4'hF;
              state_r     <= S_BBRD;
            end else begin
              tgt_valid_r <= 1'b1;
              tgt_addr_r  <= {req_addr[31:2], 2'b00};
              tgt_write_r <= req_write;
              tgt_be_r    <= req_lanes[3:0]; // RULE_10
              tgt_wdata_r <= req_wide[31:0];
              be_hi_r     <= req_lanes[7:4];
              wdata_hi_r  <= req_wide[63:32];
              ext_addr_r  <= dec_sel[`T_XMEM] ? req_addr[`XMEM_AW-1:0] : 24'h000000; // RULE_16
              state_r     <= S_BEAT0;
            end
          end
        end
        S_BEAT0: begin
          if (beat_ok) begin
            rd0_r <= tgt_rdata;
            if (tgt_err || be_hi_r == 4'h0) begin
              tgt_valid_r  <= 1'b0;
              resp_valid_r <= 1'b1;
              resp_err_r   <= tgt_err;
              resp_rdata_r <= (tgt_err || write_r) ? 32'h00000000 :
                              extract({32'h00000000, tgt_rdata}, off_r, size_r);
              state_r      <= S_IDLE;
            end else begin
              // The access crosses a word boundary: a second beat follows.
              tgt_addr_r  <= tgt_addr_r + 32'h00000004; // RULE_10
              tgt_be_r    <= be_hi_r;
              tgt_wdata_r <= wdata_hi_r;
              ext_addr_r  <= tgt_sel_r[`T_XMEM] ? ext_addr_r + 24'h000004 : 24'h000000; // RULE_16
              state_r     <= S_BEAT1;
            end
          end
        end
        S_BEAT1: begin
          if (beat_ok) begin
            tgt_valid_r  <= 1'b0;
            resp_valid_r <= 1'b1;
            resp_err_r   <= tgt_err;
            resp_rdata_r <= (tgt_err || write_r) ? 32'h00000000 :
                            extract({tgt_rdata, rd0_r}, off_r, size_r); // RULE_10
            state_r      <= S_IDLE;
          end
        end
        S_BBRD: begin
          if (beat_ok) begin
            if (tgt_err || !write_r) begin
              tgt_valid_r  <= 1'b0;
              resp_valid_r <= 1'b1;
              resp_err_r   <= tgt_err;
              resp_rdata_r <= tgt_err ? 32'h00000000 : bb_bit; // RULE_09
              state_r      <= S_IDLE;
            end else begin
              tgt_write_r <= 1'b1;
              tgt_wdata_r <= bb_merged; // RULE_08
              state_r     <= S_BBWR;
            end
          end
        end
        S_BBWR: begin
          if (beat_ok) begin
            tgt_valid_r  <= 1'b0;
            tgt_write_r  <= 1'b0;
            resp_valid_r <= 1'b1;
            resp_err_r   <= tgt_err;
            resp_rdata_r <= 32'h00000000;
            state_r      <= S_IDLE;
          end
        end
        default: begin
          tgt_valid_r <= 1'b0;
          state_r     <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* system_address_map_decoder_tb.sv */
// Self-checking bench for the system address map decoder.
// Assumes the decoder, the target model and the checker bound to the decoder.
`include "addr_map_defs.vh"

module system_address_map_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk = 0, rst = 1, req_valid = 0, req_write = 0, req_fetch = 0, req_debug = 0, err_in = 0;
  reg [31:0] req_addr = 0, req_wdata = 0, got_rd, got_ext;
  reg [1:0] req_size = 0;
  reg [2:0] stall = 0;
  reg [8:0] got_sel;
  reg [3:0] got_path;
  reg got_err, seen, got_dbg;
  integer beats, failures = 0, comparisons = 0;
  wire req_ready, resp_valid_r, resp_err_r, tgt_valid_r, tgt_write_r, tgt_debug_r, tgt_ready, tgt_err;
  wire path_icode, path_dcode, path_sys, path_ppb, bb_lock;
  wire [31:0] resp_rdata_r, tgt_addr_r, tgt_wdata_r, tgt_rdata;
  wire [8:0] tgt_sel_r;
  wire [3:0] tgt_be_r;
  wire [23:0] ext_addr_r;

  always #20 clk = ~clk;

  system_address_map_decoder i_system_address_map_decoder (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_write(req_write), .req_size(req_size),
    .req_wdata(req_wdata), .req_fetch(req_fetch), .req_debug(req_debug), .resp_valid_r(resp_valid_r),
    .resp_err_r(resp_err_r), .resp_rdata_r(resp_rdata_r), .tgt_valid_r(tgt_valid_r), .tgt_sel_r(tgt_sel_r),
    .tgt_addr_r(tgt_addr_r), .tgt_write_r(tgt_write_r), .tgt_be_r(tgt_be_r), .tgt_wdata_r(tgt_wdata_r),
    .tgt_debug_r(tgt_debug_r), .tgt_ready(tgt_ready), .tgt_rdata(tgt_rdata), .tgt_err(tgt_err),
    .path_icode(path_icode), .path_dcode(path_dcode), .path_sys(path_sys), .path_ppb(path_ppb),
    .ext_addr_r(ext_addr_r), .bb_lock(bb_lock));

  mem_target i_mem_target (.clk(clk), .rst(rst), .tgt_valid_r(tgt_valid_r), .tgt_addr_r(tgt_addr_r),
    .tgt_write_r(tgt_write_r), .tgt_be_r(tgt_be_r), .tgt_wdata_r(tgt_wdata_r), .stall(stall),
    .err_in(err_in), .tgt_ready(tgt_ready), .tgt_rdata(tgt_rdata), .tgt_err(tgt_err));

  task give_verdict;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // One access: present at a falling edge, collect first beat and response
  // ----------------------------------------------------------------------
  task acc(input [31:0] a, input w, input [1:0] sz, input [31:0] d, input f);
    integer i;
    begin
      @(negedge clk);
      beats = 0; seen = 0; got_sel = 0; got_path = 0; got_ext = 0;
      req_addr = a; req_write = w; req_size = sz; req_wdata = d; req_fetch = f; req_valid = 1;
      @(negedge clk);
      req_valid = 0;
      req_addr = ~a;
      for (i = 0; i < 40 && !resp_valid_r; i = i + 1) begin
        if (tgt_valid_r && !seen) begin
          seen = 1; got_sel = tgt_sel_r; got_ext = {8'h00, ext_addr_r}; got_dbg = tgt_debug_r;
          got_path = {path_ppb, path_sys, path_dcode, path_icode};
        end
        if (tgt_valid_r && tgt_ready) beats = beats + 1;
        @(negedge clk);
      end
      if (!resp_valid_r) begin
        failures = failures + 1;
        give_verdict;
      end
      got_err = resp_err_r; got_rd = resp_rdata_r;
    end
  endtask

  task rt(input [31:0] a, input f, input [3:0] s, input [1:0] p);
    begin
      acc(a, 0, `SZ_WORD, 0, f);
      chk(got_err, 0);
      chk(got_sel, (32'h1 << s) & 32'h1FF);
      chk(got_path, 32'h1 << p);
    end
  endtask

  task er(input [31:0] a, input f);
    begin
      acc(a, 0, `SZ_WORD, 0, f);
      chk(got_err, 1);
      chk(beats, 0);
    end
  endtask

  task t_route;
    begin
      rt(32'h00000100, 1, `T_FLASH, `P_ICODE);
      rt(32'h1FFF8000, 0, `T_SRAMC, `P_DCODE);
      rt(32'h20007FFC, 0, `T_SRAMS, `P_SYS);
      rt(32'h20000010, 1, `T_SRAMS, `P_SYS);
      rt(32'h400042FC, 0, `T_CLK, `P_SYS);
      rt(32'h40004300, 0, `T_PERI, `P_SYS);
      rt(32'h400054FC, 0, `T_EMIFR, `P_SYS);
      rt(32'hA0000000, 0, `T_XPER, `P_SYS);
      chk(got_dbg, 0);
      rt(32'hE0000000, 0, 4'h9, `P_PPB);
      rt(32'hE00FFFFC, 0, 4'h9, `P_PPB);
      req_debug = 1;
      rt(32'hE0100000, 0, `T_SYSI, `P_SYS);
      chk(got_dbg, 1);
      req_debug = 0;
      rt(32'h60ABCDE8, 1, `T_XMEM, `P_SYS);
      chk(got_ext, 32'h00ABCDE8);
    end
  endtask

  task t_errors;
    begin
      er(32'h00100000, 0);
      er(32'h20008000, 0);
      er(32'h61000000, 0);
      er(32'h40000000, 1);
      er(32'hE0000000, 1);
      er(32'h22100000, 0);
    end
  endtask

  // A slow target stretches both beats of the read-modify-write.
  task t_bitband;
    begin
      stall = 3'h2;
      acc(32'h20000000, 1, `SZ_WORD, 32'h00000000, 0);
      acc(32'h2200000C, 1, `SZ_WORD, 32'h00000001, 0);
      chk(beats, 2);
      acc(32'h20000000, 0, `SZ_WORD, 0, 0);
      chk(got_rd, 32'h00000008);
      acc(32'h2200000C, 0, `SZ_WORD, 0, 0);
      chk(got_rd, 1);
      acc(32'h2200000C, 1, `SZ_BYTE, 32'hFFFFFFFE, 0);
      acc(32'h2200000C, 0, `SZ_WORD, 0, 0);
      chk(got_rd, 0);
      acc(32'h2200017C, 1, `SZ_WORD, 32'h00000001, 0);
      acc(32'h20000008, 0, `SZ_WORD, 0, 0);
      chk(got_rd, 32'h80000000);
      chk(got_sel, 32'h1 << `T_SRAMS);
      stall = 3'h0;
    end
  endtask

  task t_unaligned;
    begin
      acc(32'h20000010, 1, `SZ_WORD, 32'h33221100, 0);
      acc(32'h20000012, 1, `SZ_WORD, 32'hDDCCBBAA, 0);
      chk(beats, 2);
      acc(32'h20000010, 0, `SZ_WORD, 0, 0);
      chk(got_rd, 32'hBBAA1100);
      acc(32'h20000013, 0, `SZ_HALF, 0, 0);
      chk(got_rd, 32'h0000CCBB);
      chk(beats, 2);
    end
  endtask

  task t_tgt_err;
    begin
      err_in = 1;
      acc(32'h40004000, 0, `SZ_WORD, 0, 0);
      chk(got_err, 1);
      acc(32'h20000011, 0, `SZ_WORD, 0, 0);
      chk(beats, 1);
      err_in = 0;
    end
  endtask

  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    chk(req_ready, 1);
    chk(resp_valid_r, 0);
    t_route;
    t_errors;
    t_bitband;
    t_unaligned;
    t_tgt_err;
    give_verdict;
  end
endmodule
